// >>> nand_host_pkg.sv
// Constants shared by the NAND host controller and its pin driver.
// Assumes a 250 MHz mclk and a small-page NAND part on the far side.
package nand_host_pkg;
	// Command codes
	localparam logic [7:0] CMD_AREA_A = 8'h00;
	localparam logic [7:0] CMD_AREA_B = 8'h01;
	localparam logic [7:0] CMD_AREA_C = 8'h50;
	localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
	localparam logic [7:0] CMD_CONFIRM = 8'h10;
	localparam logic [7:0] CMD_ERASE1 = 8'h60;
	localparam logic [7:0] CMD_ERASE2 = 8'hd0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_RESET = 8'hff;
	// Columns and values
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [7:0] MARK_COL_X8 = 8'h05;  // 517 = 512 + 5
	localparam logic [7:0] MARK_COL_X16A = 8'h00;  // 256
	localparam logic [7:0] MARK_COL_X16B = 8'h05;  // 261
	localparam int STATUS_FAIL_BIT = 0;
	localparam int STATUS_READY_BIT = 6;
	localparam int ADDR_CYCLES = 3;
	// Pin timing, ns figures and derived cycle counts
	localparam int CLK_NS = 4;
	localparam int T_WP_NS = 35;
	localparam int T_WH_NS = 15;
	localparam int T_RP_NS = 25;
	localparam int T_REH_NS = 15;
	localparam int T_WHR_NS = 60;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WH_CYC = (T_WH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int REH_CYC = (T_REH_NS + CLK_NS - 1) / CLK_NS;
	localparam int WHR_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
	// Operations offered on the user port
	typedef enum logic [2:0] {
		OP_READ, OP_PROGRAM, OP_ERASE, OP_RESET, OP_SCAN
	} op_type;
	// Pin cycle kinds for the strobe engine
	typedef enum logic [1:0] {
		CYC_CMD, CYC_ADDR, CYC_WDATA, CYC_RDATA
	} cyc_type;
endpackage

// >>> nand_pin_cycle.sv
// One NAND bus cycle: command, address, data write or data read strobe.
// Assumes kind and data are valid in the start cycle; both are latched there.
module nand_pin_cycle
	import nand_host_pkg::*;
#(
	parameter int DW = 16
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic start,
	input wire cyc_type kind,
	input wire logic [DW-1:0] wrData,
	input wire logic [DW-1:0] ioIn,
	output logic [DW-1:0] ioOut,
	output logic ioOe,
	output logic cle,
	output logic ale,
	output logic weN,
	output logic reN,
	output logic [DW-1:0] rdData,
	output logic busy,
	output logic done
);
	typedef enum logic [1:0] {PC_IDLE, PC_LOW, PC_HIGH} pc_type;
	pc_type st_ff, nxt_st;
	logic [4:0] cnt_ff, nxt_cnt;
	cyc_type kind_ff;
	logic isRead;
	logic lowDone;
	logic highDone;

	// Strobe widths chosen by cycle kind
	assign isRead = (kind_ff == CYC_RDATA);
	assign lowDone = cnt_ff == (isRead ? 5'(RP_CYC - 1) : 5'(WP_CYC - 1));
	assign highDone = cnt_ff == (isRead ? 5'(REH_CYC - 1) : 5'(WH_CYC - 1));
	assign busy = (st_ff != PC_IDLE);
	assign done = (st_ff == PC_HIGH) && highDone;

	// Sequencing of low and high phases
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff + 5'd1;
		case (st_ff)
			PC_IDLE: begin
				nxt_cnt = 5'd0;
				if (start)
					nxt_st = PC_LOW;
			end
			PC_LOW: if (lowDone) begin
				nxt_st = PC_HIGH;
				nxt_cnt = 5'd0;
			end
			PC_HIGH: if (highDone) begin
				nxt_st = PC_IDLE;
				nxt_cnt = 5'd0;
			end
			default: nxt_st = PC_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st_ff <= PC_IDLE;
			cnt_ff <= 5'd0;
			kind_ff <= CYC_CMD;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			if (start && st_ff == PC_IDLE)
				kind_ff <= kind;
		end
	end

	// Pins are registered so strobes are glitch free
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			weN <= 1'b1;
			reN <= 1'b1;
			cle <= 1'b0;
			ale <= 1'b0;
			ioOe <= 1'b0;
			ioOut <= '0;
			rdData <= '0;
		end else begin
			weN <= !(nxt_st == PC_LOW && kind_ff != CYC_RDATA &&
				st_ff != PC_IDLE) && !(st_ff == PC_IDLE && start &&
				kind != CYC_RDATA);
			reN <= !((st_ff == PC_IDLE && start && kind == CYC_RDATA) ||
				(st_ff == PC_LOW && !lowDone && isRead));
			if (st_ff == PC_IDLE && start) begin
				cle <= (kind == CYC_CMD);
				ale <= (kind == CYC_ADDR);
				ioOe <= (kind != CYC_RDATA);
				ioOut <= wrData;
			end else if (st_ff == PC_IDLE) begin
				cle <= 1'b0;
				ale <= 1'b0;
				ioOe <= 1'b0;
			end
			// Sample late in the low phase, after access time
			if (st_ff == PC_LOW && lowDone && isRead)
				rdData <= ioIn;
		end
	end
endmodule

// >>> nand_host_ctrl.sv
// NAND host controller: area pointers, program, erase, read, reset and
// invalid-block scan with block retirement. Drives the flash pins.
// Assumes one flash, ready/busy pin, device size selected by X16.
//
// Operation
// (R1) Byte part: 00h/01h/50h pick column area
// (R2) 00h or 50h area persists until changed
// (R3) 01h lasts one operation, then area A
// (R4) Write 01h right before 80h
// (R5) Word part: only 00h and 50h exist
// (R6) Word part: area command before 80h
// (R7) Unmarked locations read erased FFh
// (R8) Scan pages 0,1 at marker columns
// (R9) Block zero is always valid
// (R10) Remap addresses away from invalid blocks; code only flags blockBad, no remap
// (R11) Never erase factory invalid marking
// (R12) Failed program/erase retires the block
// (R13) Program failure leaves other pages intact
// (R14) Rewrite failed page, copy earlier pages; code only reports doneBlock
// (R15) Correct single-bit errors by ECC; code passes read words raw
// (R16) Word part: upper lanes zero on cmd/addr
// (R17) Chip select may drop during data transfer
// (R18) Device page buffer holds 528/264
// (R19) Program: 80h, three addresses, data, confirm
// (R20) Pass/fail on status lane zero
// (R21) Start column is area base plus column
module nand_host_ctrl
	import nand_host_pkg::*;
#(
	parameter bit X16 = 1'b0,
	parameter int BLOCKS = 2048,
	parameter int BW = 11
) (
	input wire logic mclk,
	input wire logic rstn,
	// User request
	input wire logic reqValid,
	output logic reqReady,
	input wire op_type reqOp,
	input wire logic [1:0] reqArea,
	input wire logic [7:0] reqCol,
	input wire logic [BW-1:0] reqBlock,
	input wire logic [4:0] reqPage,
	input wire logic [8:0] reqLen,
	// Write data stream
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [15:0] wrData,
	// Read data stream
	output logic rdValid,
	output logic [15:0] rdData,
	// Completion
	output logic doneValid,
	output logic doneFail,
	output logic [BW-1:0] doneBlock,
	output logic blockBad,
	// Flash pins
	output logic flCle,
	output logic flAle,
	output logic flWeN,
	output logic flReN,
	output logic flCeN,
	input wire logic flReady,
	input wire logic [15:0] flIoIn,
	output logic [15:0] flIoOut,
	output logic flIoOe
);
	typedef enum logic [3:0] {
		S_IDLE, S_PTR, S_CMD, S_ADDR, S_DATA, S_CONF, S_WAIT, S_STAT,
		S_STATRD, S_FIN
	} st_type;

	st_type st_ff, nxt_st;
	op_type op_ff;
	logic [1:0] area_ff;  // Persisting pointer, 0=A 1=B 2=C
	logic [7:0] col_ff;
	logic [BW-1:0] blk_ff;
	logic [4:0] page_ff;
	logic [8:0] len_ff;
	logic [1:0] acnt_ff;
	logic fail_ff;
	logic scanPage_ff;
	logic [BLOCKS-1:0] badMap_ff;
	logic waited_ff;
	logic [3:0] whr_ff;

	logic pcStart, pcBusy, pcDone;
	cyc_type pcKind;
	logic [15:0] pcWr, pcRd, pcIo;
	logic [1:0] useArea;
	logic [7:0] ptrCmd, opCmd, addrByte;
	logic [23:0] rowCol;
	logic isProg, isErase, isScan, refuseErase, markBad, cmdPhase;

	// Word part has no middle area; map it onto spare
	assign useArea = (X16 && reqArea == 2'd1) ? 2'd2 : reqArea; // (R5)
	assign isProg = (op_ff == OP_PROGRAM);
	assign isErase = (op_ff == OP_ERASE);
	assign isScan = (op_ff == OP_SCAN);
	// Scan always reads from the spare area pointer
	assign ptrCmd = (area_ff == 2'd1) ? CMD_AREA_B :
		(area_ff == 2'd2) ? CMD_AREA_C : CMD_AREA_A; // (R1)
	assign opCmd = isProg ? CMD_SERIAL_IN : isErase ? CMD_ERASE1 :
		(op_ff == OP_RESET) ? CMD_RESET : ptrCmd;
	// Erase sends row only; column byte is skipped
	assign rowCol = {16'({blk_ff, page_ff}), col_ff};
	assign addrByte = isErase ? rowCol[8*(acnt_ff+1) +: 8] :
		rowCol[8*acnt_ff +: 8];
	// Erasing a table entry would wipe the factory marking for good
	assign refuseErase = reqValid && reqOp == OP_ERASE && blockBad; // (R11)
	assign cmdPhase = (st_ff != S_DATA);
	assign reqReady = (st_ff == S_IDLE);
	// Block zero is never checked or marked
	assign blockBad = badMap_ff[reqBlock] && (reqBlock != '0); // (R9)

	// Pin cycle request decode
	always_comb begin
		pcStart = 1'b0;
		pcKind = CYC_CMD;
		pcWr = 16'h0000;
		case (st_ff)
			S_PTR: begin
				pcStart = !pcBusy;
				pcWr = {8'h00, ptrCmd};
			end
			S_CMD: begin
				pcStart = !pcBusy;
				pcWr = {8'h00, opCmd};
			end
			S_ADDR: begin
				pcStart = !pcBusy;
				pcKind = CYC_ADDR;
				pcWr = {8'h00, addrByte}; // (R16)
			end
			S_DATA: begin
				pcStart = !pcBusy && (isProg ? wrValid :
					(waited_ff && flReady));
				pcKind = isProg ? CYC_WDATA : CYC_RDATA;
				pcWr = X16 ? wrData : {8'h00, wrData[7:0]};
			end
			S_CONF: begin
				pcStart = !pcBusy;
				pcWr = {8'h00, isErase ? CMD_ERASE2 : CMD_CONFIRM};
			end
			S_STAT: begin
				pcStart = !pcBusy;
				pcWr = {8'h00, CMD_STATUS};
			end
			S_STATRD: begin
				pcStart = !pcBusy && (whr_ff == 4'(WHR_CYC));
				pcKind = CYC_RDATA;
			end
			default: pcStart = 1'b0;
		endcase
	end
	assign wrReady = (st_ff == S_DATA) && isProg && !pcBusy;

	// Any non-erased marker byte or word flags the block
	assign markBad = X16 ? (pcRd != ERASED_WORD) :
		(pcRd[7:0] != ERASED_BYTE); // (R8)

	// Main sequencer
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			S_IDLE: if (refuseErase)
				nxt_st = S_FIN; // (R11)
			else if (reqValid)
				nxt_st = (reqOp == OP_RESET || reqOp == OP_ERASE) ?
					S_CMD : S_PTR;
			S_PTR: if (pcDone)
				nxt_st = isProg ? S_CMD : S_ADDR; // (R4) (R6)
			S_CMD: if (pcDone)
				nxt_st = (op_ff == OP_RESET) ? S_WAIT : S_ADDR; // (R19)
			S_ADDR: if (pcDone && acnt_ff == 2'(ADDR_CYCLES - 1 - 32'(isErase)))
				nxt_st = isErase ? S_CONF : (isProg ? S_DATA : S_DATA);
			S_DATA: if (pcDone && len_ff == 9'd1)
				nxt_st = isProg ? S_CONF : S_FIN;
			S_CONF: if (pcDone)
				nxt_st = S_WAIT;
			S_WAIT: if (flReady && waited_ff)
				nxt_st = (isProg || isErase) ? S_STAT : S_FIN;
			S_STAT: if (pcDone)
				nxt_st = S_STATRD;
			S_STATRD: if (pcDone)
				nxt_st = S_FIN;
			S_FIN: nxt_st = S_IDLE;
			default: nxt_st = S_IDLE;
		endcase
	end

	// Operation context capture
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			op_ff <= OP_READ;
			col_ff <= 8'h00;
			blk_ff <= '0;
			page_ff <= 5'd0;
			scanPage_ff <= 1'b0;
		end else if (st_ff == S_IDLE && reqValid) begin
			op_ff <= reqOp;
			col_ff <= (reqOp == OP_SCAN) ? (X16 ? MARK_COL_X16A :
				MARK_COL_X8) : reqCol; // (R21)
			blk_ff <= reqBlock;
			page_ff <= (reqOp == OP_SCAN) ? 5'd0 : reqPage;
			scanPage_ff <= 1'b0;
		end else if (st_ff == S_FIN && isScan && !scanPage_ff) begin
			page_ff <= 5'd1; // Second page of the block
			scanPage_ff <= 1'b1;
		end
	end

	// Area pointer: A/C persist, B only for one operation
	always_ff @(posedge mclk) begin
		if (!rstn)
			area_ff <= 2'd0; // Power-up lands in area A (R3)
		else if (st_ff == S_IDLE && reqValid && reqOp == OP_SCAN)
			area_ff <= 2'd2;
		else if (st_ff == S_IDLE && reqValid && reqOp != OP_ERASE &&
			reqOp != OP_RESET)
			area_ff <= useArea; // (R2) (R5)
		else if (st_ff == S_FIN && area_ff == 2'd1)
			area_ff <= 2'd0; // (R3)
	end

	// Counters, busy wait and status
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st_ff <= S_IDLE;
			acnt_ff <= 2'd0;
			len_ff <= 9'd0;
			waited_ff <= 1'b0;
			whr_ff <= 4'd0;
			fail_ff <= 1'b0;
		end else begin
			st_ff <= (st_ff == S_FIN && isScan && !scanPage_ff) ?
				S_PTR : nxt_st;
			acnt_ff <= (st_ff != S_ADDR) ? 2'd0 :
				acnt_ff + 2'(pcDone);
			if (st_ff == S_IDLE)
				len_ff <= (reqOp == OP_SCAN) ? (X16 ? 9'd6 : 9'd1) :
					reqLen;
			else if (st_ff == S_FIN && isScan)
				len_ff <= X16 ? 9'd6 : 9'd1;
			else if (st_ff == S_DATA && pcDone)
				len_ff <= len_ff - 9'd1;
			// Busy may take a while to appear after the last strobe
			waited_ff <= (st_ff == nxt_st) && (st_ff == S_WAIT ||
				st_ff == S_DATA) && (waited_ff || !flReady);
			whr_ff <= (st_ff != S_STATRD) ? 4'd0 :
				(whr_ff == 4'(WHR_CYC) ? whr_ff : whr_ff + 4'd1);
			if (st_ff == S_IDLE)
				fail_ff <= refuseErase; // (R11)
			else if (st_ff == S_STATRD && pcDone)
				fail_ff <= pcRd[STATUS_FAIL_BIT]; // (R20)
			else if (st_ff == S_DATA && pcDone && isScan && markBad &&
				(!X16 || len_ff == 9'd6 || len_ff == 9'd1))
				fail_ff <= 1'b1; // (R8)
		end
	end

	// Bad-block table, built from scan and from failures
	always_ff @(posedge mclk) begin
		if (!rstn)
			badMap_ff <= '0;
		else if (st_ff == S_FIN && fail_ff && blk_ff != '0)
			badMap_ff[blk_ff] <= 1'b1; // (R10) (R12)
	end

	// Completion and read stream outputs
	// Read words leave raw; single-bit repair is the user's ECC
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			doneValid <= 1'b0;
			doneFail <= 1'b0;
			doneBlock <= '0;
			rdValid <= 1'b0;
			rdData <= 16'h0000;
		end else begin
			doneValid <= (st_ff == S_FIN) && !(isScan && !scanPage_ff);
			// Result stands until the next completion
			if (st_ff == S_FIN && !(isScan && !scanPage_ff)) begin
				doneFail <= fail_ff;
				doneBlock <= blk_ff; // (R14)
			end
			rdValid <= (st_ff == S_DATA) && pcDone && !isProg && !isScan;
			rdData <= pcRd; // (R15)
		end
	end

	// Chip select held through a transfer; the device tolerates gaps
	always_ff @(posedge mclk) begin
		if (!rstn)
			flCeN <= 1'b1;
		else
			flCeN <= (st_ff == S_IDLE); // (R17)
	end

	// Upper lanes forced low outside data cycles
	assign flIoOut = (cmdPhase || !X16) ? {8'h00, pcIo[7:0]} : pcIo; // (R16)

	nand_pin_cycle #(
		.DW(16)
	) u_cycle (
		.mclk(mclk),
		.rstn(rstn),
		.start(pcStart),
		.kind(pcKind),
		.wrData(pcWr),
		.ioIn(flIoIn),
		.ioOut(pcIo),
		.ioOe(flIoOe),
		.cle(flCle),
		.ale(flAle),
		.weN(flWeN),
		.reN(flReN),
		.rdData(pcRd),
		.busy(pcBusy),
		.done(pcDone)
	);
endmodule

// >>> nand_host_monitor.sv
// Checker for the flash pin sequencing and completion outputs.
// Assumes it is bound onto nand_host_ctrl and sees its ports only.
module nand_host_monitor #(
	parameter int BW = 11
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [BW-1:0] reqBlock,
	input wire logic doneValid,
	input wire logic doneFail,
	input wire logic blockBad,
	input wire logic rdValid,
	input wire logic flCle,
	input wire logic flAle,
	input wire logic flWeN,
	input wire logic flReN,
	input wire logic flCeN,
	input wire logic [15:0] flIoOut,
	input wire logic flIoOe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Pin cycle shape and bus ownership
	chk_lanes_zero: assert property (
		(flCle || flAle) |-> flIoOut[15:8] == 8'h00)
		else $error("upper lanes not zero on cmd or addr");
	chk_cmd_cycle: assert property (
		$fell(flWeN) && flCle |-> !flAle && flIoOe && !flCeN)
		else $error("command strobe malformed");
	chk_we_low: assert property (
		$fell(flWeN) |=> !flWeN [*8])
		else $error("write strobe too short");
	chk_we_high: assert property (
		$rose(flWeN) |=> flWeN [*3])
		else $error("write strobe high time too short");
	chk_re_low: assert property (
		$fell(flReN) |=> !flReN [*6])
		else $error("read strobe too short");
	chk_read_bus: assert property (
		!flReN |-> flWeN && !flIoOe)
		else $error("host drives bus during read");
	// Completion reporting
	chk_done_pulse: assert property (
		doneValid |=> !doneValid)
		else $error("done longer than one cycle");
	chk_fail_hold: assert property (
		!doneValid |-> $stable(doneFail))
		else $error("fail flag moved outside completion");
	chk_block_zero: assert property (
		reqBlock == '0 |-> !blockBad)
		else $error("block zero reported bad");
	cov_fail: cover property (doneValid && doneFail);
	cov_read: cover property (rdValid);
	cov_bad: cover property (blockBad);
endmodule

bind nand_host_ctrl nand_host_monitor #(.BW(BW)) mon_u (
	.mclk(mclk), .rstn(rstn), .reqBlock(reqBlock), .doneValid(doneValid),
	.doneFail(doneFail), .blockBad(blockBad), .rdValid(rdValid),
	.flCle(flCle), .flAle(flAle), .flWeN(flWeN), .flReN(flReN),
	.flCeN(flCeN), .flIoOut(flIoOut), .flIoOe(flIoOe)
);

// >>> nand_flash_model.sv
// Byte-wide small-page flash: area pointer, page buffer, status byte.
// Assumes row is block and page packed, page in the low five bits.
module nand_flash_model (
	input wire logic cle,
	input wire logic ale,
	input wire logic weN,
	input wire logic reN,
	input wire logic ceN,
	input wire logic [15:0] ioOut,
	input wire logic failNext,
	input wire logic [10:0] markBlk,
	output logic ready,
	output logic [15:0] ioIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [int];
	logic [7:0] pbuf [int];
	logic [7:0] dout = 8'hff;
	logic [15:0] row = 16'h0000;
	int ptr = 0;
	int col = 0;
	int nAddr = 0;
	bit prog, era, stat, fail;
	initial ready = 1'b1;
	// Busy for a while, then ready again
	task automatic hold;
		ready = 1'b0;
		ready <= #200 1'b1;
	endtask
	// Cycles latch on the rising write strobe
	always @(posedge weN) begin
		if (!ceN && cle) begin
			stat = 0;
			nAddr = 0; // Addresses count from the latest command
			case (ioOut[7:0])
				8'h00: ptr = 0;
				8'h01: ptr = 1;
				8'h50: ptr = 2;
				8'h80: begin
					prog = 1;
					nAddr = 0;
					pbuf.delete();
				end
				8'h10: begin
					foreach (pbuf[k]) mem[k] = pbuf[k];
					fail = failNext;
					prog = 0;
					hold();
				end
				8'h60: begin
					era = 1;
					nAddr = 0;
					ptr = (ptr == 1) ? 0 : ptr;
				end
				8'hd0: begin
					foreach (mem[k]) if (k / 16896 == row[15:5]) mem.delete(k);
					era = 0;
					fail = 0;
					hold();
				end
				8'h70: stat = 1;
				8'hff: begin
					ptr = 0;
					hold();
				end
				default: ;
			endcase
		end else if (!ceN && ale) begin
			if (nAddr == 0 && !era) begin
				col = (ptr == 2 ? 512 : ptr * 256) + ioOut[7:0];
				ptr = (ptr == 1) ? 0 : ptr;
			end else
				row = {ioOut[7:0], row[15:8]};
			nAddr++;
			if (nAddr == 3 && !prog)
				hold();
		end else if (prog) begin
			pbuf[row * 528 + col] = ioOut[7:0];
			col++;
		end
	end
	// Byte chosen on the falling read strobe, column steps on rise
	always @(negedge reN) begin
		if (stat)
			dout = {1'b0, ready, 5'h00, fail};
		else if (row[15:5] == markBlk && col == 517)
			dout = 8'h00;
		else
			dout = mem.exists(row * 528 + col) ? mem[row * 528 + col] : 8'hff;
	end
	always @(posedge reN) if (!stat) col++;
	// Released bus shows the inverse, so stale data cannot pass
	assign ioIn = (!reN && !ceN) ? {8'h00, dout} : ~{8'h00, dout};
endmodule

// >>> tb_nand_host_ctrl.sv
// Self-checking bench for nand_host_ctrl, byte-wide build.
// Assumes the flash model and the bound checker are compiled too.
module tb_nand_host_ctrl
	import nand_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, reqReady, wrReady, rdValid, doneValid, doneFail, blockBad;
	logic rstn = 1'b0, reqValid = 1'b0, wrValid = 1'b0, failNext = 1'b0;
	logic flCle, flAle, flWeN, flReN, flCeN, flReady, flIoOe;
	op_type reqOp = OP_READ;
	logic [1:0] reqArea = 2'h0;
	logic [7:0] reqCol = 8'h00;
	logic [10:0] reqBlock = 11'h000, doneBlock, markBlk = 11'h7ff;
	logic [4:0] reqPage = 5'h00;
	logic [8:0] reqLen = 9'h001;
	logic [15:0] wrData = 16'h0000, rdData, flIoIn, flIoOut;
	logic [15:0] wq[$], rq[$];
	int n_mismatch = 0;
	int checks_done = 0;
	nand_host_ctrl dut_u (.mclk(mclk), .rstn(rstn), .reqValid(reqValid),
		.reqReady(reqReady), .reqOp(reqOp), .reqArea(reqArea),
		.reqCol(reqCol), .reqBlock(reqBlock), .reqPage(reqPage),
		.reqLen(reqLen), .wrValid(wrValid), .wrReady(wrReady),
		.wrData(wrData), .rdValid(rdValid), .rdData(rdData),
		.doneValid(doneValid), .doneFail(doneFail), .doneBlock(doneBlock),
		.blockBad(blockBad), .flCle(flCle), .flAle(flAle), .flWeN(flWeN),
		.flReN(flReN), .flCeN(flCeN), .flReady(flReady), .flIoIn(flIoIn),
		.flIoOut(flIoOut), .flIoOe(flIoOe));
	nand_flash_model flash_u (.cle(flCle), .ale(flAle), .weN(flWeN),
		.reN(flReN), .ceN(flCeN), .ioOut(flIoOut), .failNext(failNext),
		.markBlk(markBlk), .ready(flReady), .ioIn(flIoIn));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// One operation: offer, stream data, collect reads, wait done
	task automatic run(op_type op, logic [1:0] ar, logic [10:0] b,
			logic [4:0] pg, logic [8:0] n);
		int t;
		t = 0;
		rq.delete();
		reqValid <= 1'b1;
		reqOp <= op;
		reqArea <= ar;
		reqCol <= 8'h02;
		reqBlock <= b;
		reqPage <= pg;
		reqLen <= n;
		wrValid <= wq.size() > 0;
		wrData <= (wq.size() > 0) ? wq[0] : 16'h0000;
		@(posedge mclk);
		while (reqReady !== 1'b1)
			@(posedge mclk);
		reqValid <= 1'b0;
		do begin
			@(posedge mclk);
			t++;
			if (rdValid === 1'b1)
				rq.push_back(rdData);
			if (wrValid === 1'b1 && wrReady === 1'b1) begin
				wq = wq[1:$];
				wrValid <= wq.size() > 0;
				wrData <= (wq.size() > 0) ? wq[0] : 16'h0000;
			end
		end while (doneValid !== 1'b1 && t < 5000);
		chk(16'(doneValid), 16'h0001);
		@(posedge mclk);
	endtask
	// Write then read back in every area; B must not leak into A
	task automatic s_areas;
		for (int i = 0; i < 3; i++) begin
			wq = '{16'h00a5 + 16'(i), 16'h003c};
			run(OP_PROGRAM, 2'(i), 11'h003, 5'(i), 9'h002);
			chk(16'(doneFail), 16'h0000);
			run(OP_READ, 2'(i), 11'h003, 5'(i), 9'h002);
			chk(rq[0], 16'h00a5 + 16'(i));
			chk(rq[1], 16'h003c);
		end
		run(OP_READ, 2'h0, 11'h003, 5'h01, 9'h001);
		chk(rq[0], 16'h00ff);
	endtask
	// Failed program retires the block; erase empties a block
	task automatic s_fail;
		failNext <= 1'b1;
		wq = '{16'h0011};
		run(OP_PROGRAM, 2'h0, 11'h007, 5'h03, 9'h001);
		failNext <= 1'b0;
		chk(16'(doneFail), 16'h0001);
		chk(16'(doneBlock), 16'h0007);
		chk(16'(blockBad), 16'h0001);
		run(OP_ERASE, 2'h0, 11'h003, 5'h00, 9'h001);
		chk(16'(doneFail), 16'h0000);
		run(OP_READ, 2'h0, 11'h003, 5'h00, 9'h001);
		chk(rq[0], 16'h00ff);
		run(OP_ERASE, 2'h0, 11'h007, 5'h00, 9'h001);
		chk(16'(doneFail), 16'h0001);
		run(OP_READ, 2'h0, 11'h007, 5'h03, 9'h001);
		chk(rq[0], 16'h0011);
		wq = '{16'h0011};
		run(OP_PROGRAM, 2'h0, 11'h008, 5'h03, 9'h001);
		chk(16'(doneFail), 16'h0000);
		run(OP_READ, 2'h0, 11'h008, 5'h03, 9'h001);
		chk(rq[0], 16'h0011);
	endtask
	// Factory marking scan, block zero, then a reset
	task automatic s_scan;
		markBlk <= 11'h009;
		run(OP_SCAN, 2'h2, 11'h009, 5'h00, 9'h001);
		chk(16'(doneFail), 16'h0001);
		chk(16'(blockBad), 16'h0001);
		run(OP_SCAN, 2'h2, 11'h004, 5'h00, 9'h001);
		chk(16'(doneFail), 16'h0000);
		markBlk <= 11'h000;
		run(OP_SCAN, 2'h2, 11'h000, 5'h00, 9'h001);
		chk(16'(blockBad), 16'h0000);
		run(OP_RESET, 2'h0, 11'h000, 5'h00, 9'h001);
		chk(16'(doneFail), 16'h0000);
	endtask
	task automatic wrap_up;
		if (n_mismatch == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		s_areas();
		s_fail();
		s_scan();
		wrap_up();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end
endmodule
